// ===== rtl/ccc_defines.svh
`ifndef CCC_DEFINES_SVH
`define CCC_DEFINES_SVH
// Register offsets on the plain register port (byte addresses).
`define CCC_OFS_IDLE_LEVEL     8'h04
`define CCC_OFS_MODE_CONFIG    8'h18
`define CCC_OFS_ENABLE_POL     8'h20
`define CCC_OFS_COMPARE_VALUE  8'h34
`define CCC_OFS_OUTPUT_CONTROL 8'h44
// Reset values.
`define CCC_RST_MODE_CONFIG    8'h00
`define CCC_RST_ENABLE_POL     4'h0
`define CCC_RST_COMPARE        16'h0000
`define CCC_RST_OUTPUT_CONTROL 16'h0000
`define CCC_RST_IDLE_LEVEL     2'h0
// Mode configuration fields.
`define CCC_MC_DIR_LSB         0
`define CCC_MC_FAST_BIT        2
`define CCC_MC_PRELOAD_BIT     3
`define CCC_MC_OCMODE_LSB      4
`define CCC_MC_DIVIDER_LSB     2
`define CCC_MC_FILTER_LSB      4
// Enable and polarity fields.
`define CCC_EP_CHANNEL_ON      0
`define CCC_EP_MAIN_POL        1
`define CCC_EP_COMP_EN         2
`define CCC_EP_COMP_POL        3
// Output control fields.
`define CCC_OC_DEAD_LSB        0
`define CCC_OC_LOCK_LSB        8
`define CCC_OC_IDLE_OFF_BIT    10
`define CCC_OC_RUN_OFF_BIT     11
`define CCC_OC_MASTER_BIT      15
// Idle level fields.
`define CCC_IL_MAIN_BIT        0
`define CCC_IL_COMP_BIT        1
// Timing counts in kernel clock cycles.
`define CCC_FAST_LATENCY       3
`define CCC_NORMAL_LATENCY     5
// Filter length for the illegible code 0100.
`define CCC_FILTER_N_CODE4     4'd6
`endif

// ===== rtl/ccc_pkg.sv
package ccc_pkg;

  // Channel direction and capture source.
  typedef enum logic [1:0] {
    CCC_DIR_OUTPUT  = 2'b00,
    CCC_DIR_LINE1   = 2'b01,
    CCC_DIR_LINE2   = 2'b10,
    CCC_DIR_TRIGGER = 2'b11
  } ccc_dir_t;

  // Compare reference modes.
  typedef enum logic [2:0] {
    CCC_OCM_FROZEN   = 3'b000,
    CCC_OCM_SET      = 3'b001,
    CCC_OCM_CLEAR    = 3'b010,
    CCC_OCM_TOGGLE   = 3'b011,
    CCC_OCM_FORCE_LO = 3'b100,
    CCC_OCM_FORCE_HI = 3'b101,
    CCC_OCM_PWM1     = 3'b110,
    CCC_OCM_PWM2     = 3'b111
  } ccc_oc_mode_t;

  // Pin-side view of the two outputs.
  typedef struct packed {
    logic main_out;
    logic main_oe;
    logic comp_out;
    logic comp_oe;
  } ccc_pins_t;

  // Register port request.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } ccc_bus_req_t;

endpackage : ccc_pkg

// ===== rtl/ccc_channel.sv
`timescale 1ns/1ps
`include "ccc_defines.svh"

module ccc_channel (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire ccc_pkg::ccc_bus_req_t bus_req,
  output      logic [15:0]        reg_rdata,
  input  wire logic               update_event,
  input  wire logic [15:0]        counter_value,
  input  wire logic               counter_down,
  input  wire logic               trigger_edge,
  input  wire logic               input_line_one,
  input  wire logic               input_line_two,
  input  wire logic               internal_trigger_input,
  input  wire logic               internal_trigger_selected,
  output      ccc_pkg::ccc_pins_t pins,
  output      logic               capture_event
);

  // Software-visible state.
  logic [7:0]  mode_cfg_reg;
  logic        channel_on_reg;
  logic        main_pol_reg;
  logic        comp_en_reg;
  logic        comp_pol_reg;
  logic [15:0] preload_reg;
  logic [15:0] active_cmp_reg;
  logic [7:0]  dead_time_reg;
  logic [1:0]  lock_reg;
  logic        idle_off_reg;
  logic        run_off_reg;
  logic        master_en_reg;
  logic        main_idle_reg;
  logic        comp_idle_reg;

  // Decoded fields.
  ccc_pkg::ccc_dir_t     dir;
  ccc_pkg::ccc_oc_mode_t oc_mode;
  logic                  is_output;
  logic                  lock3_out;
  logic                  pol_lock_comp;
  logic                  wr_mode;
  logic                  wr_enable;
  logic                  wr_cmp;
  logic                  wr_octl;
  logic                  wr_idle;

  assign dir       = ccc_pkg::ccc_dir_t'(mode_cfg_reg[`CCC_MC_DIR_LSB +: 2]);
  assign oc_mode   = ccc_pkg::ccc_oc_mode_t'(mode_cfg_reg[`CCC_MC_OCMODE_LSB +: 3]);
  assign is_output = (dir == ccc_pkg::CCC_DIR_OUTPUT);
  assign lock3_out = (lock_reg == 2'h3) && is_output;
  assign pol_lock_comp = lock_reg[1] && is_output;
  assign wr_mode   = bus_req.wr && (bus_req.addr == `CCC_OFS_MODE_CONFIG);
  assign wr_enable = bus_req.wr && (bus_req.addr == `CCC_OFS_ENABLE_POL);
  assign wr_cmp    = bus_req.wr && (bus_req.addr == `CCC_OFS_COMPARE_VALUE);
  assign wr_octl   = bus_req.wr && (bus_req.addr == `CCC_OFS_OUTPUT_CONTROL);
  assign wr_idle   = bus_req.wr && (bus_req.addr == `CCC_OFS_IDLE_LEVEL);

  // Mode configuration: direction and output control bits have their own guards.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_cfg_reg <= `CCC_RST_MODE_CONFIG;
    end else if (wr_mode) begin
      if (!channel_on_reg) begin
        mode_cfg_reg[1:0] <= bus_req.wdata[1:0];
      end
      if (!lock3_out) begin
        mode_cfg_reg[7:2] <= bus_req.wdata[7:2];
      end
    end
  end

  // Enable and polarity; main polarity freezes once lock reaches level two, the complementary one only in output mode.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {comp_pol_reg, comp_en_reg, main_pol_reg, channel_on_reg} <= `CCC_RST_ENABLE_POL;
    end else if (wr_enable) begin
      channel_on_reg <= bus_req.wdata[`CCC_EP_CHANNEL_ON];
      comp_en_reg    <= bus_req.wdata[`CCC_EP_COMP_EN];
      if (!lock_reg[1]) begin
        main_pol_reg <= bus_req.wdata[`CCC_EP_MAIN_POL];
      end
      if (!pol_lock_comp) begin
        comp_pol_reg <= bus_req.wdata[`CCC_EP_COMP_POL];
      end
    end
  end

  // Output control: lock may only be raised from zero, so it sticks until reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {master_en_reg, run_off_reg, idle_off_reg, lock_reg, dead_time_reg} <= 13'h0000;
    end else if (wr_octl) begin
      master_en_reg <= bus_req.wdata[`CCC_OC_MASTER_BIT];
      if (lock_reg == 2'h0) begin
        lock_reg      <= bus_req.wdata[`CCC_OC_LOCK_LSB +: 2];
        dead_time_reg <= bus_req.wdata[`CCC_OC_DEAD_LSB +: 8];
      end
      if (!lock_reg[1]) begin
        run_off_reg  <= bus_req.wdata[`CCC_OC_RUN_OFF_BIT];
        idle_off_reg <= bus_req.wdata[`CCC_OC_IDLE_OFF_BIT];
      end
    end
  end

  // Idle levels are frozen from lock level one upward.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {comp_idle_reg, main_idle_reg} <= `CCC_RST_IDLE_LEVEL;
    end else if (wr_idle && (lock_reg == 2'h0)) begin
      main_idle_reg <= bus_req.wdata[`CCC_IL_MAIN_BIT];
      comp_idle_reg <= bus_req.wdata[`CCC_IL_COMP_BIT];
    end
  end

  // Input capture path signals.
  logic [2:0]  line1_sync_reg;
  logic [2:0]  line2_sync_reg;
  logic        src_level;
  logic        capture_take;

  // Compare value: a capture shares the register with the preload, as software reads it back.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      preload_reg <= `CCC_RST_COMPARE;
    end else if (capture_take) begin
      preload_reg <= counter_value;
    end else if (wr_cmp) begin
      preload_reg <= bus_req.wdata;
    end
  end

  // Active compare value: direct on write without preload, else only on update.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_cmp_reg <= `CCC_RST_COMPARE;
    end else if (wr_cmp && !mode_cfg_reg[`CCC_MC_PRELOAD_BIT]) begin
      active_cmp_reg <= bus_req.wdata;
    end else if (update_event && mode_cfg_reg[`CCC_MC_PRELOAD_BIT]) begin
      active_cmp_reg <= preload_reg;
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        `CCC_OFS_MODE_CONFIG:    reg_rdata <= {8'h00, mode_cfg_reg[7] & ~is_output, mode_cfg_reg[6:0]};
        `CCC_OFS_ENABLE_POL:     reg_rdata <= {12'h000, comp_pol_reg, comp_en_reg,
                                               main_pol_reg, channel_on_reg};
        `CCC_OFS_COMPARE_VALUE:  reg_rdata <= preload_reg;
        `CCC_OFS_OUTPUT_CONTROL: reg_rdata <= {master_en_reg, 3'h0, run_off_reg, idle_off_reg,
                                               lock_reg, dead_time_reg};
        `CCC_OFS_IDLE_LEVEL:     reg_rdata <= {14'h0000, comp_idle_reg, main_idle_reg};
        default:                 reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // Compare reference generation with the fast trigger path.
  logic        cmp_match;
  logic        pwm_mode;
  logic        pwm_level;
  logic        trig_q_reg;
  logic        ref_reg;

  assign cmp_match = (counter_value == active_cmp_reg);
  assign pwm_mode  = (oc_mode == ccc_pkg::CCC_OCM_PWM1) || (oc_mode == ccc_pkg::CCC_OCM_PWM2);
  // Level the reference takes once the count has reached the compare value.
  assign pwm_level = (oc_mode == ccc_pkg::CCC_OCM_PWM2);

  // Trigger edge is held one stage so that edge to pin totals three cycles.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      trig_q_reg <= 1'b0;
    end else begin
      trig_q_reg <= trigger_edge && mode_cfg_reg[`CCC_MC_FAST_BIT] && pwm_mode;
    end
  end

  // Reference level; without the fast path a trigger only acts through the counter.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_reg <= 1'b0;
    end else if (trig_q_reg) begin
      ref_reg <= pwm_level;
    end else begin
      unique case (oc_mode)
        ccc_pkg::CCC_OCM_FROZEN:   ref_reg <= ref_reg;
        ccc_pkg::CCC_OCM_SET:      ref_reg <= ref_reg | cmp_match;
        ccc_pkg::CCC_OCM_CLEAR:    ref_reg <= ref_reg & ~cmp_match;
        ccc_pkg::CCC_OCM_TOGGLE:   ref_reg <= ref_reg ^ cmp_match;
        ccc_pkg::CCC_OCM_FORCE_LO: ref_reg <= 1'b0;
        ccc_pkg::CCC_OCM_FORCE_HI: ref_reg <= 1'b1;
        ccc_pkg::CCC_OCM_PWM1:     ref_reg <= counter_down ? (counter_value <= active_cmp_reg)
                                                           : (counter_value < active_cmp_reg);
        ccc_pkg::CCC_OCM_PWM2:     ref_reg <= counter_down ? (counter_value > active_cmp_reg)
                                                           : (counter_value >= active_cmp_reg);
      endcase
    end
  end

  // Dead-time counter restarts on every reference change and when master enable falls.
  logic [7:0] dead_cnt_reg;
  logic       ref_seen_reg;
  logic       master_q_reg;
  logic       dead_done;

  assign dead_done = (dead_cnt_reg == 8'h00) && (ref_seen_reg == ref_reg);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dead_cnt_reg <= 8'h00;
      ref_seen_reg <= 1'b0;
      master_q_reg <= 1'b0;
    end else begin
      ref_seen_reg <= ref_reg;
      master_q_reg <= master_en_reg;
      if ((ref_seen_reg != ref_reg) || (master_q_reg && !master_en_reg)) begin
        dead_cnt_reg <= dead_time_reg;
      end else if (dead_cnt_reg != 8'h00) begin
        dead_cnt_reg <= dead_cnt_reg - 8'h01;
      end
    end
  end

  // Output pin matrix; both pins come from one register stage.
  ccc_pkg::ccc_pins_t pins_next;

  always_comb begin
    pins_next = '0;
    if (!is_output) begin
      pins_next = '0;
    end else if (!master_en_reg) begin
      if (channel_on_reg || comp_en_reg) begin
        // The polarity values come first, idle levels once the dead-time has run out.
        // The cycle right after master enable falls still shows polarity, as the counter has not loaded yet.
        pins_next.main_oe = idle_off_reg;
        pins_next.comp_oe = idle_off_reg;
        pins_next.main_out = ((dead_cnt_reg == 8'h00) && !master_q_reg) ? main_idle_reg : main_pol_reg;
        pins_next.comp_out = ((dead_cnt_reg == 8'h00) && !master_q_reg) ? comp_idle_reg : comp_pol_reg;
      end
    end else begin
      unique case ({channel_on_reg, comp_en_reg})
        2'b00: begin
          pins_next.main_out = run_off_reg & main_pol_reg;
          pins_next.comp_out = run_off_reg & comp_pol_reg;
        end
        2'b10: begin
          pins_next.main_out = ref_reg ^ main_pol_reg;
          pins_next.main_oe  = 1'b1;
          pins_next.comp_out = run_off_reg & comp_pol_reg;
          pins_next.comp_oe  = run_off_reg;
        end
        2'b01: begin
          pins_next.comp_out = ref_reg ^ comp_pol_reg;
          pins_next.comp_oe  = 1'b1;
          pins_next.main_out = run_off_reg & main_pol_reg;
          pins_next.main_oe  = run_off_reg;
        end
        2'b11: begin
          pins_next.main_out = (ref_reg & dead_done) ^ main_pol_reg;
          pins_next.comp_out = (~ref_reg & dead_done) ^ comp_pol_reg;
          pins_next.main_oe  = 1'b1;
          pins_next.comp_oe  = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pins <= '0;
    end else begin
      pins <= pins_next;
    end
  end

  // Pin inputs pass three flip-flops; only stages two and three are looked at.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line1_sync_reg <= 3'h0;
      line2_sync_reg <= 3'h0;
    end else begin
      line1_sync_reg <= {line1_sync_reg[1:0], input_line_one};
      line2_sync_reg <= {line2_sync_reg[1:0], input_line_two};
    end
  end

  // Agreed level of each line; a change counts once stages two and three match.
  logic line1_lvl_reg;
  logic line2_lvl_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line1_lvl_reg <= 1'b0;
      line2_lvl_reg <= 1'b0;
    end else begin
      if (line1_sync_reg[2] == line1_sync_reg[1]) begin
        line1_lvl_reg <= line1_sync_reg[2];
      end
      if (line2_sync_reg[2] == line2_sync_reg[1]) begin
        line2_lvl_reg <= line2_sync_reg[2];
      end
    end
  end

  // Source per direction; the trigger source is meaningful only when it is selected.
  always_comb begin
    unique case (dir)
      ccc_pkg::CCC_DIR_OUTPUT:  src_level = 1'b0;
      ccc_pkg::CCC_DIR_LINE1:   src_level = line1_lvl_reg;
      ccc_pkg::CCC_DIR_LINE2:   src_level = line2_lvl_reg;
      ccc_pkg::CCC_DIR_TRIGGER: src_level = internal_trigger_input & internal_trigger_selected;
    endcase
  end

  // Filter code to sample divider (as log2) and agreeing sample count.
  function automatic logic [6:0] ccc_filter_cfg(input logic [3:0] code);
    unique case (code)
      4'h0: ccc_filter_cfg = {3'd0, 4'd1};
      4'h1: ccc_filter_cfg = {3'd0, 4'd2};
      4'h2: ccc_filter_cfg = {3'd0, 4'd4};
      4'h3: ccc_filter_cfg = {3'd0, 4'd8};
      4'h4: ccc_filter_cfg = {3'd1, `CCC_FILTER_N_CODE4};
      4'h5: ccc_filter_cfg = {3'd1, 4'd8};
      4'h6: ccc_filter_cfg = {3'd2, 4'd6};
      4'h7: ccc_filter_cfg = {3'd2, 4'd8};
      4'h8: ccc_filter_cfg = {3'd3, 4'd6};
      4'h9: ccc_filter_cfg = {3'd3, 4'd8};
      4'hA: ccc_filter_cfg = {3'd4, 4'd5};
      4'hB: ccc_filter_cfg = {3'd4, 4'd6};
      4'hC: ccc_filter_cfg = {3'd4, 4'd8};
      4'hD: ccc_filter_cfg = {3'd5, 4'd5};
      4'hE: ccc_filter_cfg = {3'd5, 4'd6};
      4'hF: ccc_filter_cfg = {3'd5, 4'd8};
    endcase
  endfunction : ccc_filter_cfg

  // Sample divider runs on the dead-time sample clock, which here equals the kernel clock.
  logic [6:0] filt_cfg;
  logic [4:0] samp_div_reg;
  logic [4:0] samp_mask;
  logic       samp_en;
  logic [3:0] agree_cnt_reg;
  logic       filt_lvl_reg;

  assign filt_cfg  = ccc_filter_cfg(mode_cfg_reg[`CCC_MC_FILTER_LSB +: 4]);
  assign samp_mask = 5'(({5'h00, 1'b1} << filt_cfg[6:4]) - 6'h01);
  assign samp_en   = ((samp_div_reg & samp_mask) == 5'h00);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      samp_div_reg <= 5'h00;
    end else begin
      samp_div_reg <= samp_div_reg + 5'h01;
    end
  end

  // A transition is taken after N consecutive samples that differ from the filtered level.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      agree_cnt_reg <= 4'h0;
      filt_lvl_reg  <= 1'b0;
    end else if (src_level == filt_lvl_reg) begin
      agree_cnt_reg <= 4'h0;
    end else if (samp_en) begin
      if (agree_cnt_reg + 4'h1 >= filt_cfg[3:0]) begin
        filt_lvl_reg  <= src_level;
        agree_cnt_reg <= 4'h0;
      end else begin
        agree_cnt_reg <= agree_cnt_reg + 4'h1;
      end
    end
  end

  // Edge selection by polarity pair, then the event divider.
  logic       filt_q_reg;
  logic       rise;
  logic       fall;
  logic       edge_hit;
  logic [2:0] div_cnt_reg;
  logic [2:0] div_mask;

  assign rise = filt_lvl_reg & ~filt_q_reg;
  assign fall = ~filt_lvl_reg & filt_q_reg;
  always_comb begin
    unique case ({comp_pol_reg, main_pol_reg})
      2'b00:   edge_hit = rise;
      2'b01:   edge_hit = fall;
      2'b11:   edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  end
  assign div_mask     = 3'(({3'h0, 1'b1} << mode_cfg_reg[`CCC_MC_DIVIDER_LSB +: 2]) - 4'h1);
  assign capture_take = edge_hit && !is_output && channel_on_reg
                        && ((div_cnt_reg & div_mask) == 3'h0);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      filt_q_reg <= 1'b0;
    end else begin
      filt_q_reg <= filt_lvl_reg;
    end
  end

  // The divider counts every qualified edge and sits at zero while the channel is off.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_reg <= 3'h0;
    end else if (!channel_on_reg) begin
      div_cnt_reg <= 3'h0;
    end else if (edge_hit && !is_output) begin
      div_cnt_reg <= (div_cnt_reg + 3'h1) & div_mask;
    end
  end

  // Capture strobe for the surrounding flag logic.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      capture_event <= 1'b0;
    end else begin
      capture_event <= capture_take;
    end
  end

endmodule : ccc_channel

// ===== tb/ccc_channel_asserts.sv
`timescale 1ns/1ps
module ccc_channel_asserts (
  input wire logic                  clk,
  input wire logic                  rstn,
  input wire ccc_pkg::ccc_bus_req_t bus_req,
  input wire logic [15:0]           reg_rdata,
  input wire ccc_pkg::ccc_pins_t    pins,
  input wire logic                  capture_event
);
  logic       on_q, cen_q, mp_q, cp_q, moe_q, run_q, idl_q;
  logic [1:0] lock_q, dir_q;
  logic [2:0] st_q;
  logic       quiet;
  // Shadow of the control bits; the pin checks only look once writes have settled.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {on_q, cen_q, mp_q, cp_q, moe_q, run_q, idl_q, lock_q, dir_q, st_q} <= '0;
    end else begin
      st_q <= bus_req.wr ? 3'h0 : st_q + {2'h0, st_q != 3'h7}; // Saturating age.
      if (bus_req.wr && bus_req.addr == 8'h18 && !on_q) dir_q <= bus_req.wdata[1:0];
      if (bus_req.wr && bus_req.addr == 8'h20) begin
        on_q  <= bus_req.wdata[0];
        cen_q <= bus_req.wdata[2];
        if (lock_q < 2'h2) mp_q <= bus_req.wdata[1];
        if (lock_q < 2'h2 || dir_q != 2'h0) cp_q <= bus_req.wdata[3];
      end
      if (bus_req.wr && bus_req.addr == 8'h44) begin
        moe_q <= bus_req.wdata[15];
        if (lock_q == 2'h0) lock_q <= bus_req.wdata[9:8];
        if (lock_q < 2'h2) {run_q, idl_q} <= bus_req.wdata[11:10];
      end
    end
  end
  // Output mode with four quiet cycles since the last write.
  assign quiet = st_q > 3'h3 && dir_q == 2'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_reserved_zero: assert property ($past(bus_req.rd && bus_req.addr == 8'h20) |-> reg_rdata[15:4] == 12'h000)
    else $error("Upper enable bits not zero.");
  a_rdata_quiet: assert property (!$past(bus_req.rd) |-> reg_rdata == 16'h0000)
    else $error("Read data outside read slot.");
  a_unmapped_read: assert property ($past(bus_req.rd && bus_req.addr == 8'h10) |-> reg_rdata == 16'h0000)
    else $error("Unmapped read not zero.");
  a_capture_gate: assert property (capture_event |-> $past(on_q))
    else $error("Capture while channel off.");
  a_single_main: assert property (quiet && moe_q && !run_q && on_q && !cen_q |->
    pins.main_oe && !pins.comp_oe && !pins.comp_out) else $error("Single output wrong.");
  a_both_off: assert property (quiet && moe_q && run_q && !on_q && !cen_q |-> !pins.main_oe &&
    !pins.comp_oe && pins.main_out == mp_q && pins.comp_out == cp_q) else $error("Off outputs wrong.");
  a_partner_held: assert property (quiet && moe_q && run_q && on_q && !cen_q |->
    pins.comp_oe && pins.comp_out == cp_q) else $error("Partner not held inactive.");
  a_idle_enable: assert property (quiet && !moe_q |-> pins.main_oe == (idl_q && (on_q || cen_q))
    && pins.comp_oe == pins.main_oe) else $error("Idle enables wrong.");
  cover property (capture_event);
  cover property (quiet && !moe_q && idl_q);
  cover property (quiet && moe_q && run_q && on_q);
endmodule : ccc_channel_asserts
bind ccc_channel ccc_channel_asserts u_asserts (.clk(clk), .rstn(rstn), .bus_req(bus_req),
  .reg_rdata(reg_rdata), .pins(pins), .capture_event(capture_event));

// ===== tb/ccc_channel_tb.sv
`timescale 1ns/1ps
module ccc_channel_tb;
  logic                  clk, rstn, upd, l1, l2, cap, trg, tsel;
  logic [15:0]           cnt, rdata, cv;
  ccc_pkg::ccc_bus_req_t req;
  ccc_pkg::ccc_pins_t    pins;
  int                    failures, checks, cyc, ncap, n0, d;

  ccc_channel dut (.clk(clk), .rstn(rstn), .bus_req(req), .reg_rdata(rdata), .update_event(upd),
    .counter_value(cnt), .counter_down(1'b0), .trigger_edge(trg), .input_line_one(l1),
    .input_line_two(l2), .internal_trigger_input(l1), .internal_trigger_selected(tsel),
    .pins(pins), .capture_event(cap));

  // Free-running 25 MHz clock.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Capture counter and hang guard; the limit is far above the planned run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cap === 1'b1) ncap <= ncap + 1;
    if (cyc == 30000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (failures == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rd

  task automatic pchk(input logic [3:0] e);
    repeat (6) @(negedge clk);
    chk({12'h000, pins}, {12'h000, e});
  endtask : pchk

  // One-cycle trigger pulse; the fast path reaches the pins on the second edge after it is sampled.
  task automatic trig(input logic [15:0] e);
    @(posedge clk);
    trg <= 1'b1;
    @(posedge clk);
    trg <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({12'h000, pins}, e);
  endtask : trig

  // Pulses are long enough to pass the longest kernel-clock filter.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      {l1, l2} <= 2'h3;
      repeat (12) @(posedge clk);
      {l1, l2} <= 2'h0;
      repeat (12) @(posedge clk);
    end
  endtask : pulse

  initial begin
    void'($urandom(36967));
    cv = 16'(51 + $urandom_range(1000));
    {rstn, upd, l1, l2, trg, tsel, failures, checks, cyc, ncap} = '0;
    req = '0;
    cnt = 16'h0032;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h20, 16'h0000);
    rd(8'h10, 16'h0000);
    wr(8'h20, 16'hFFFF);
    rd(8'h20, 16'h000F);
    wr(8'h44, 16'h8000);
    wr(8'h18, 16'h0068);
    wr(8'h20, 16'h0001);
    wr(8'h34, cv);
    pchk(4'b0100);
    rd(8'h34, cv);
    @(posedge clk) upd <= 1'b1;
    @(posedge clk) upd <= 1'b0;
    pchk(4'b1100);
    wr(8'h20, 16'h0003);
    pchk(4'b0100);
    wr(8'h20, 16'h0001);
    wr(8'h18, 16'h0020);
    wr(8'h34, 16'h0032);
    pchk(4'b0100);
    wr(8'h44, 16'h8800);
    wr(8'h20, 16'h0000);
    pchk(4'b0000);
    wr(8'h20, 16'h0001);
    pchk(4'b0101);
    wr(8'h44, 16'h0000);
    pchk(4'b0000);
    wr(8'h44, 16'h0400);
    pchk(4'b0101);
    wr(8'h18, 16'h0021);
    rd(8'h18, 16'h0020);
    for (d = 0; d < 4; d++) begin
      wr(8'h20, 16'h0000);
      wr(8'h18, 16'(d * 20 + d % 2 + 1));
      // Falling edges on the second pass, both edges on the last, so eight pulses give two captures there.
      wr(8'h20, 16'(d == 1 ? 3 : d == 3 ? 11 : 1));
      cnt <= 16'($urandom_range(65535));
      n0 = ncap;
      pulse(8);
      chk(16'(ncap - n0), 16'(d == 3 ? 2 : 8 >> d));
      rd(8'h34, cnt);
    end
    wr(8'h20, 16'h0000);
    n0 = ncap;
    pulse(2);
    chk(16'(ncap - n0), 16'h0000);
    // Trigger capture counts only while the internal trigger is selected.
    wr(8'h18, 16'h0003);
    wr(8'h20, 16'h0001);
    n0 = ncap;
    pulse(2);
    chk(16'(ncap - n0), 16'h0000);
    @(posedge clk) tsel <= 1'b1;
    n0 = ncap;
    pulse(2);
    chk(16'(ncap - n0), 16'h0002);
    // PWM mode 2 below the compare value, first with the fast path, then without it.
    wr(8'h20, 16'h0000);
    wr(8'h18, 16'h0074);
    cnt <= 16'h0032;
    wr(8'h34, cv);
    wr(8'h44, 16'h8000);
    wr(8'h20, 16'h0001);
    pchk(4'b0100);
    trig(16'h000C);
    pchk(4'b0100);
    wr(8'h18, 16'h0070);
    trig(16'h0004);
    // Both outputs with a dead-time of five cycles, then the reference rises.
    wr(8'h44, 16'h8005);
    wr(8'h20, 16'h0005);
    pchk(4'b0111);
    @(posedge clk) cnt <= 16'hFFFF;
    repeat (8) @(negedge clk);
    chk({12'h000, pins}, 16'h0005);
    @(negedge clk);
    chk({12'h000, pins}, 16'h000D);
    // Master enable falls: polarity values for the dead-time, then the idle levels.
    wr(8'h04, 16'h0003);
    wr(8'h44, 16'h0405);
    repeat (2) @(negedge clk);
    chk({12'h000, pins}, 16'h0005);
    repeat (5) @(negedge clk);
    chk({12'h000, pins}, 16'h0005);
    @(negedge clk);
    chk({12'h000, pins}, 16'h000F);
    wr(8'h18, 16'h0060);
    wr(8'h44, 16'h8300);
    wr(8'h20, 16'h000E);
    rd(8'h20, 16'h0004);
    wr(8'h18, 16'h0078);
    rd(8'h18, 16'h0060);
    end_of_test();
  end
endmodule : ccc_channel_tb
